//--- hw/smq_switch_qos.sv
// forwarding decision, mirroring, rate limiting, shaping and egress scheduling of a 3-port switch
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`default_nettype none
`include "smq_params.svh"

module smq_switch_qos
	import smq_pkg::*;
#(
	parameter int BURST_BITS = 16384,	// ingress bucket ceiling in bits
	parameter int NPORT      = 3,
	parameter int NQ         = 4
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// avalon-mm register slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// ingress frame descriptor after address lookup
	input  wire logic        in_valid_in,
	input  wire logic [1:0]  in_port_in,
	input  wire logic [1:0]  in_prio_in,
	input  wire logic [10:0] in_len_in,
	input  wire logic        in_mcast_in,
	input  wire logic        in_bcast_in,
	input  wire logic        in_hit_in,
	input  wire logic [2:0]  in_hit_mask_in,
	input  wire logic        in_vid_miss_in,
	input  wire logic        in_mld_in,
	input  wire logic        in_err_in,
	// forwarding result
	output logic             fwd_valid_out,
	output logic [2:0]       fwd_mask_out,
	output logic             fwd_drop_out,
	// egress side, per port
	input  wire logic [5:0]  link_speed_in,
	input  wire logic [11:0] eg_pending_in,
	input  wire logic [2:0]  eg_ready_in,
	input  wire logic [2:0]  eg_done_in,
	input  wire logic [32:0] eg_done_len_in,
	output logic [2:0]       eg_grant_out,
	output logic [5:0]       eg_queue_out
);
	// cycles per credit tick, at least one
	localparam int TICK_CYC = (`SMQ_TICK_NS / `SMQ_CLK_NS) < 1 ? 1 : (`SMQ_TICK_NS / `SMQ_CLK_NS);
	localparam smq_credit_t BURST = smq_credit_t'(BURST_BITS);

	// the port and queue counts are wired into the field layout
	if (NPORT != 3 || NQ != 4 || BURST_BITS < 1 || BURST_BITS > 262143) begin : g_chk
		$error("smq_switch_qos: unsupported parameter values");
	end

	// frame cost in bits, optional gap and preamble bytes added
	function automatic smq_credit_t smq_cost(input logic [10:0] len, input logic ifg,
		input logic pre);
		logic [14:0] b;
		b = {4'h0, len} + (ifg ? `SMQ_IFG_BYTES : 15'h0000) + (pre ? `SMQ_PRE_BYTES : 15'h0000);
		smq_cost = $signed({2'b00, b, 3'b000});
	endfunction

	// limiting active only for a nonzero rate within link speed
	function automatic logic smq_lim_on(input logic [7:0] rate, input logic [1:0] spd);
		smq_lim_on = (rate != 8'h00)
			&& !(spd == SP_10 && rate > `SMQ_LIM_10M)
			&& !(spd == SP_100 && rate > `SMQ_LIM_100M);
	endfunction

	// byte-enable merge of a write into a register
	function automatic logic [31:0] smq_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			smq_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// software registers
	logic [31:0] ctrl;		// host, sniff sets, sniffer port, modes
	logic [31:0] unk;		// unknown destination sets
	logic [31:0] pcfg   [3];	// per-port queue and limiter config
	logic [31:0] irate  [3];	// ingress rate per priority, Mbps
	logic [31:0] erate  [3];	// egress rate per queue, Mbps
	logic [31:0] cslope [3];	// shaper idle slope per queue, Mbps
	logic [15:0] drop_cnt;		// frames dropped by ingress limiting
	logic [2:0]  host_mask;		// effective host port, one-hot or empty

	// bus handshake: one wait cycle, then the answer
	logic        ack_q;
	wire  logic  bus_req = avs_read_in | avs_write_in;
	wire  logic  wr_go   = avs_write_in & ack_q;
	wire  logic  [7:0] a = avs_address_in;
	assign avs_waitrequest_out = bus_req & ~ack_q;

	// acknowledge toggles so each request gets exactly one answer edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req & ~ack_q;
		end
	end

	// read mux, unmapped words read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (a == `SMQ_REG_CTRL) rd_mux = ctrl;
		if (a == `SMQ_REG_UNKNOWN) rd_mux = unk;
		if (a == `SMQ_REG_STATUS) rd_mux = {13'h0000, host_mask, drop_cnt};
		for (int p = 0; p < 3; p++) begin
			if (a == `SMQ_REG_PCFG0 + 8'(4 * p)) rd_mux = pcfg[p];
			if (a == `SMQ_REG_IRATE0 + 8'(4 * p)) rd_mux = irate[p];
			if (a == `SMQ_REG_ERATE0 + 8'(4 * p)) rd_mux = erate[p];
			if (a == `SMQ_REG_CSLOPE0 + 8'(4 * p)) rd_mux = cslope[p];
		end
	end

	// read data loaded during the wait cycle, stands at the answer edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in & ~ack_q) begin
			avs_readdata_out <= rd_mux;
		end
	end

	// global register writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl <= `SMQ_CTRL_RST;
			unk  <= `SMQ_UNK_RST;
		end else if (wr_go) begin
			if (a == `SMQ_REG_CTRL) ctrl <= smq_merge(ctrl, avs_writedata_in, avs_byteenable_in);
			if (a == `SMQ_REG_UNKNOWN) unk <= smq_merge(unk, avs_writedata_in, avs_byteenable_in);
		end
	end

	// credit tick divider
	logic [15:0] tick_cnt;
	wire  logic  tick = (tick_cnt == 16'(TICK_CYC - 1));
	always_ff @(posedge clk_in) begin
		if (rst_in || tick) begin
			tick_cnt <= 16'h0000;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	// control fields
	wire logic [2:0] host_en  = ctrl[`SMQ_CTRL_HOST_LSB +: 3];
	wire logic [2:0] rx_snf   = ctrl[`SMQ_CTRL_RXSNF_LSB +: 3];
	wire logic [2:0] tx_snf   = ctrl[`SMQ_CTRL_TXSNF_LSB +: 3];
	wire logic [1:0] snf_port = ctrl[`SMQ_CTRL_SNFP_LSB +: 2];
	// lowest tail-tag port wins if software sets several
	assign host_mask = host_en & (~host_en + 3'h1);
	wire logic [2:0] snf_bit = (snf_port == 2'h3) ? 3'h0 : (3'h1 << snf_port);

	// ingress classification
	wire logic       port_ok  = (in_port_in != 2'h3);
	wire logic [2:0] in_bit   = port_ok ? (3'h1 << in_port_in) : 3'h0;
	wire logic       unk_vid  = in_vid_miss_in;
	wire logic       unk_mc   = ~in_vid_miss_in & ~in_hit_in & (in_mcast_in | in_bcast_in);
	wire logic       unk_uc   = ~in_vid_miss_in & ~in_hit_in & ~in_mcast_in & ~in_bcast_in;
	wire logic [3:0] unk_sel  = unk_vid ? unk[`SMQ_UNK_VID_LSB +: 4]
		: unk_mc ? unk[`SMQ_UNK_MC_LSB +: 4] : unk[`SMQ_UNK_UC_LSB +: 4];
	// programmed set replaces flooding; empty set discards
	wire logic [2:0] unk_mask = unk_sel[`SMQ_UNK_EN_OFS] ? unk_sel[2:0] : 3'h7;
	wire logic [2:0] lk_mask  = (unk_vid | unk_mc | unk_uc) ? unk_mask : in_hit_mask_in;
	// listener discovery goes to the host alone
	wire logic [2:0] norm_mask = (in_mld_in ? host_mask : lk_mask) & ~in_bit;

	// mirroring
	wire logic rx_m  = port_ok & rx_snf[in_port_in[1:0]];
	wire logic tx_m  = |(norm_mask & tx_snf);
	wire logic mir   = ctrl[`SMQ_CTRL_AND_BIT] ? (rx_m & tx_m) : (rx_m | tx_m);
	wire logic bad_ok = ctrl[`SMQ_CTRL_BAD_BIT];
	// an errored frame reaches only the sniffer, and only when asked
	wire logic [2:0] err_mask = (bad_ok & rx_m) ? snf_bit : 3'h0;
	// or-ing the sniffer bit keeps a single copy per port
	// a trapped listener packet is never mirrored
	wire logic [2:0] ok_mask  = norm_mask | ((mir & ~in_mld_in) ? snf_bit : 3'h0);
	// the sniffer copy never goes back out of the ingress port
	wire logic [2:0] fin_mask = (in_err_in ? err_mask : ok_mask) & ~in_bit;

	// ingress limiter selection
	wire logic [31:0] in_cfg  = pcfg[in_port_in == 2'h3 ? 2'h0 : in_port_in];
	wire smq_credit_t in_cost = smq_cost(in_len_in, in_cfg[`SMQ_PCFG_IFG_BIT],
		in_cfg[`SMQ_PCFG_PRE_BIT]);
	wire logic [1:0]  in_ft   = in_cfg[`SMQ_PCFG_FT_LSB +: 2];
	// flooded unicast is an unknown unicast frame
	wire logic in_sel = (in_ft == FT_ALL) | (in_ft == FT_MCAST & in_mcast_in)
		| (in_ft == FT_BCAST & in_bcast_in) | (in_ft == FT_FLOOD & unk_uc);
	logic [11:0] ib_neg;	// bucket in deficit, per port and priority
	logic [11:0] ib_lim;	// limiter active, per port and priority
	wire logic [3:0] ib_idx = {in_port_in, in_prio_in};
	wire logic in_over = port_ok & in_sel & ib_lim[ib_idx] & ib_neg[ib_idx];
	wire logic in_drop = ~port_ok | in_over | (fin_mask == 3'h0);
	wire logic in_chg  = in_valid_in & port_ok & in_sel & ~in_over & ~in_err_in;

	// forwarding result register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fwd_valid_out <= 1'b0;
			fwd_mask_out  <= 3'h0;
			fwd_drop_out  <= 1'b0;
		end else begin
			fwd_valid_out <= in_valid_in;
			fwd_mask_out  <= in_drop ? 3'h0 : fin_mask;
			fwd_drop_out  <= in_valid_in & in_drop;
		end
	end

	// count rate-limit drops for software
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			drop_cnt <= 16'h0000;
		end else if (in_valid_in & in_over) begin
			drop_cnt <= drop_cnt + 16'h0001;
		end
	end

	// per-port registers, buckets, shapers and scheduler
	for (genvar p = 0; p < 3; p++) begin : g_port
		wire logic [1:0] spd   = link_speed_in[2*p +: 2];
		wire logic [1:0] qm    = pcfg[p][`SMQ_PCFG_QM_LSB +: 2];
		wire logic [3:0] q_on  = (qm == QM_FOUR) ? 4'hf : (qm == QM_TWO) ? 4'h3 : 4'h1;
		// only the top two of four, or queue 1 of two, may be shaped
		wire logic [3:0] cbs_ok = (qm == QM_FOUR) ? 4'hc : (qm == QM_TWO) ? 4'h2 : 4'h0;
		wire logic [3:0] cbs_on = pcfg[p][`SMQ_PCFG_CBS_LSB +: 4] & cbs_ok;
		// shaping forces strict order among the rest
		wire logic use_wrr = pcfg[p][`SMQ_PCFG_WRR_BIT] & (cbs_on == 4'h0) & (qm != QM_ONE);
		wire logic [10:0] dlen = eg_done_len_in[11*p +: 11];
		wire smq_credit_t eg_cost = smq_cost(dlen, pcfg[p][`SMQ_PCFG_IFG_BIT],
			pcfg[p][`SMQ_PCFG_PRE_BIT]);
		logic [1:0] last_q;	// queue charged at frame end
		logic [3:0] eb_ok;	// egress bucket allows a start
		logic [3:0] cb_ok;	// shaper credit allows a start
		logic [3:0] wcred [4];	// round robin allowance left

		// per-port register writes
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				pcfg[p]   <= `SMQ_PCFG_RST;
				irate[p]  <= `SMQ_RATE_RST;
				erate[p]  <= `SMQ_RATE_RST;
				cslope[p] <= `SMQ_RATE_RST;
			end else if (wr_go) begin
				if (a == `SMQ_REG_PCFG0 + 8'(4 * p))
					pcfg[p] <= smq_merge(pcfg[p], avs_writedata_in, avs_byteenable_in);
				if (a == `SMQ_REG_IRATE0 + 8'(4 * p))
					irate[p] <= smq_merge(irate[p], avs_writedata_in, avs_byteenable_in);
				if (a == `SMQ_REG_ERATE0 + 8'(4 * p))
					erate[p] <= smq_merge(erate[p], avs_writedata_in, avs_byteenable_in);
				if (a == `SMQ_REG_CSLOPE0 + 8'(4 * p))
					cslope[p] <= smq_merge(cslope[p], avs_writedata_in, avs_byteenable_in);
			end
		end

		for (genvar q = 0; q < 4; q++) begin : g_q
			wire logic [7:0] ir = irate[p][8*q +: 8];
			wire logic [7:0] er = erate[p][8*q +: 8];
			wire smq_credit_t cs = $signed({12'h000, cslope[p][8*q +: 8]});
			wire logic i_lim = smq_lim_on(ir, spd);
			wire logic e_lim = smq_lim_on(er, spd);
			wire logic pend  = eg_pending_in[4*p + q];
			wire logic done  = eg_done_in[p] & (last_q == 2'(q));
			smq_credit_t ib, eb, cb;
			smq_credit_t ib_add, eb_add;
			assign ib_lim[4*p + q] = i_lim;
			assign ib_neg[4*p + q] = ib[19];
			// tokens refill per tick, the ingress bucket up to the burst ceiling, the egress one up to zero
			assign ib_add = (tick ? $signed({12'h000, ir}) : 20'sh00000) + ib;
			assign eb_add = (tick ? $signed({12'h000, er}) : 20'sh00000) + eb;
			assign eb_ok[q] = ~e_lim | ~eb[19];
			assign cb_ok[q] = ~cbs_on[q] | ~cb[19];

			// ingress bucket per priority of this port
			always_ff @(posedge clk_in) begin
				if (rst_in || !i_lim) begin
					ib <= BURST;
				end else begin
					ib <= ((ib_add > BURST) ? BURST : ib_add)
						- ((in_chg && ib_idx == 4'(4 * p + q)) ? in_cost : 20'sh00000);
				end
			end

			// egress leaky bucket: no positive credit, so frames are spaced out
			always_ff @(posedge clk_in) begin
				if (rst_in || !e_lim) begin
					eb <= 20'sh00000;
				end else begin
					eb <= ((eb_add > 20'sh00000) ? 20'sh00000 : eb_add)
						- (done ? eg_cost : 20'sh00000);
				end
			end

			// credit shaper: earns while waiting, spends on each frame
			always_ff @(posedge clk_in) begin
				if (rst_in || !cbs_on[q]) begin
					cb <= 20'sh00000;
				end else if (done) begin
					cb <= cb - eg_cost;
				end else if (!pend && !cb[19]) begin
					cb <= 20'sh00000;	// idle queue keeps no surplus
				end else if (tick && cb < BURST) begin
					cb <= cb + cs;
				end
			end
		end

		// queues allowed to start now; blocked ones just wait in memory
		wire logic [3:0] elig = eg_pending_in[4*p +: 4] & q_on & eb_ok & cb_ok;
		wire logic [3:0] w_ok = {wcred[3] != 4'h0, wcred[2] != 4'h0,
			wcred[1] != 4'h0, wcred[0] != 4'h0};
		wire logic [3:0] cand = use_wrr ? (elig & w_ok) : elig;
		// highest candidate queue, queue 3 first
		wire logic [1:0] pick = cand[3] ? 2'h3 : cand[2] ? 2'h2 : cand[1] ? 2'h1 : 2'h0;
		wire logic can_go = eg_ready_in[p] & ~eg_grant_out[p] & (cand != 4'h0);

		// grant pulse and chosen queue
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				eg_grant_out[p]      <= 1'b0;
				eg_queue_out[2*p +: 2] <= 2'h0;
				last_q               <= 2'h0;
			end else begin
				eg_grant_out[p] <= can_go;
				if (can_go) begin
					eg_queue_out[2*p +: 2] <= pick;
					last_q               <= pick;
				end
			end
		end

		// round robin allowances 8:4:2:1, reloaded once all eligible are spent
		always_ff @(posedge clk_in) begin
			if (rst_in || (elig != 4'h0 && (elig & w_ok) == 4'h0)) begin
				wcred[3] <= 4'h8;
				wcred[2] <= 4'h4;
				wcred[1] <= 4'h2;
				wcred[0] <= 4'h1;
			end else if (can_go && use_wrr) begin
				wcred[pick] <= wcred[pick] - 4'h1;
			end
		end
	end

endmodule // smq_switch_qos
`default_nettype wire

//--- hw/smq_params.svh
// register offsets, field positions, reset values and timing counts of the mirror/qos block
`ifndef SMQ_PARAMS_SVH
`define SMQ_PARAMS_SVH

// register byte offsets (one 32-bit word each)
`define SMQ_REG_CTRL      8'h00
`define SMQ_REG_UNKNOWN   8'h04
`define SMQ_REG_STATUS    8'h08
`define SMQ_REG_PCFG0     8'h10
`define SMQ_REG_IRATE0    8'h20
`define SMQ_REG_ERATE0    8'h30
`define SMQ_REG_CSLOPE0   8'h40

// control register fields
`define SMQ_CTRL_HOST_LSB   0
`define SMQ_CTRL_RXSNF_LSB  3
`define SMQ_CTRL_TXSNF_LSB  6
`define SMQ_CTRL_SNFP_LSB   9
`define SMQ_CTRL_AND_BIT    11
`define SMQ_CTRL_BAD_BIT    12

// unknown destination register: 4-bit group per class, mask [2:0], enable [3]
`define SMQ_UNK_UC_LSB   0
`define SMQ_UNK_MC_LSB   4
`define SMQ_UNK_VID_LSB  8
`define SMQ_UNK_EN_OFS   3

// per-port config fields
`define SMQ_PCFG_QM_LSB   0
`define SMQ_PCFG_WRR_BIT  2
`define SMQ_PCFG_IFG_BIT  3
`define SMQ_PCFG_PRE_BIT  4
`define SMQ_PCFG_FT_LSB   5
`define SMQ_PCFG_CBS_LSB  8

// reset values
`define SMQ_CTRL_RST     32'h0000_0600
`define SMQ_UNK_RST      32'h0000_0000
`define SMQ_PCFG_RST     32'h0000_0002
`define SMQ_RATE_RST     32'h0000_0000

// timing: credit tick period and clock period in ns
`define SMQ_TICK_NS      1000
`define SMQ_CLK_NS       100

// byte counts and link limits
`define SMQ_IFG_BYTES    15'h000c
`define SMQ_PRE_BYTES    15'h0008
`define SMQ_LIM_10M      8'h0a
`define SMQ_LIM_100M     8'h64

`endif

//--- hw/smq_pkg.sv
// types shared by the mirror/qos block
`default_nettype none
package smq_pkg;
	typedef enum logic [1:0] {QM_ONE, QM_TWO, QM_FOUR} smq_qmode_t;
	typedef enum logic [1:0] {FT_ALL, FT_MCAST, FT_BCAST, FT_FLOOD} smq_ftype_t;
	typedef enum logic [1:0] {SP_10, SP_100, SP_1000} smq_speed_t;
	typedef logic signed [19:0] smq_credit_t;
endpackage : smq_pkg
`default_nettype wire

//--- verif/smq_mac_model.sv
// egress mac model: takes grants and ends frames after a per-port delay
`default_nettype none
module smq_mac_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// scheduler side
	input  wire logic [2:0]  grant_in,
	output logic [2:0]       ready_out,
	output logic [2:0]       done_out,
	output logic [32:0]      done_len_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt [3];	// frame time left per port
	// port p is busy 1+3p cycles: port 0 prompt, port 2 slow
	always_ff @(posedge clk_in) begin
		for (int p = 0; p < 3; p++) begin
			done_out[p] <= 1'b0;
			if (rst_in) begin
				ready_out[p] <= 1'b0;
				cnt[p] <= 3'h0;
				done_len_out[p*11 +: 11] <= 11'h000;
			end else begin
				// length means nothing without done: scramble it
				done_len_out[p*11 +: 11] <= ~done_len_out[p*11 +: 11];
				if (grant_in[p]) begin
					ready_out[p] <= 1'b0;
					cnt[p] <= 3'(1 + 3 * p);
				end else if (cnt[p] == 3'h1) begin
					done_out[p] <= 1'b1;
					done_len_out[p*11 +: 11] <= 11'h040 + 11'(p);
					cnt[p] <= 3'h0;
				end else if (cnt[p] != 3'h0) begin
					cnt[p] <= cnt[p] - 3'h1;
				end else begin
					ready_out[p] <= 1'b1;	// idle: ready for the next frame
				end
			end
		end
	end
endmodule // smq_mac_model
`default_nettype wire

//--- verif/smq_switch_qos_monitor.sv
// checker for forwarding decisions and egress grants
`default_nettype none
module smq_switch_qos_monitor (
	// clock, reset, register writes
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic        avs_waitrequest_out,
	// descriptor and decision
	input wire logic        in_valid_in,
	input wire logic [1:0]  in_port_in,
	input wire logic        in_hit_in,
	input wire logic        in_mcast_in,
	input wire logic        in_bcast_in,
	input wire logic        in_vid_miss_in,
	input wire logic        in_mld_in,
	input wire logic        in_err_in,
	input wire logic        fwd_valid_out,
	input wire logic [2:0]  fwd_mask_out,
	input wire logic        fwd_drop_out,
	// egress
	input wire logic [2:0]  eg_ready_in,
	input wire logic [11:0] eg_pending_in,
	input wire logic [2:0]  eg_grant_out,
	input wire logic [5:0]  eg_queue_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] ctrl;	// shadow of control word
	logic [3:0]  unk;	// shadow of unknown unicast group
	logic        shp0;	// port 0 left plain strict once set
	logic [2:0]  host;	// lowest host bit
	logic [1:0]  top;	// highest pending queue, port 0
	logic        acc;	// accepted write
	logic        plain;	// ordinary packet, no error or trap
	assign acc = avs_write_in && !avs_waitrequest_out;
	assign host = ctrl[2:0] & (~ctrl[2:0] + 3'h1);
	assign top = eg_pending_in[3] ? 2'h3 : eg_pending_in[2] ? 2'h2 : {1'b0, eg_pending_in[1]};
	assign plain = in_valid_in && !in_err_in && !in_mld_in && in_port_in != 2'h3;
	// shadows follow writes; full byte lanes assumed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl <= 13'h0600;
			unk <= 4'h0;
			shp0 <= 1'b0;
		end else if (acc) begin
			if (avs_address_in == 8'h00) ctrl <= avs_writedata_in[12:0];
			if (avs_address_in == 8'h04) unk <= avs_writedata_in[3:0];
			// wrr or egress limit makes strict order conditional
			if ((avs_address_in == 8'h10 && avs_writedata_in[2]) ||
				(avs_address_in == 8'h30 && avs_writedata_in != 32'h0)) shp0 <= 1'b1;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_fwd_one_later: assert property (in_valid_in |=> fwd_valid_out)
		else $error("no decision after descriptor");
	a_drop_empty: assert property (fwd_drop_out |-> fwd_valid_out && fwd_mask_out == 3'h0)
		else $error("drop with nonempty mask");
	a_ingress_excluded: assert property (in_valid_in && in_port_in != 2'h3 |=> !fwd_mask_out[$past(in_port_in)])
		else $error("packet sent back to ingress");
	a_mld_host_only: assert property (in_valid_in && in_mld_in && !in_err_in && in_port_in != 2'h3 && host != 3'h0 && (host & (3'h1 << in_port_in)) == 3'h0 |=> fwd_drop_out || fwd_mask_out == $past(host))
		else $error("listener packet not host only");
	a_err_dropped: assert property (in_valid_in && in_err_in && !ctrl[12] |=> fwd_drop_out)
		else $error("bad frame not dropped");
	a_rx_sniff_copy: assert property (plain && ctrl[10:9] != 2'h3 && ctrl[10:9] != in_port_in && ctrl[3 + in_port_in] && !ctrl[11] |=> fwd_drop_out || fwd_mask_out[$past(ctrl[10:9])])
		else $error("receive mirror copy missing");
	a_unknown_discard: assert property (plain && !in_hit_in && !in_vid_miss_in && !in_mcast_in && !in_bcast_in && unk == 4'h8 && ctrl[10:9] == 2'h3 |=> fwd_drop_out)
		else $error("unknown unicast not discarded");
	a_grant_spaced: assert property (eg_grant_out != 3'h0 |=> (eg_grant_out & $past(eg_grant_out)) == 3'h0)
		else $error("grant repeated next cycle");
	a_grant_has_work: assert property (eg_grant_out[0] |-> $past(eg_ready_in[0]) && $past(eg_pending_in[3:0]) != 4'h0)
		else $error("grant without ready or work");
	a_strict_top: assert property (eg_grant_out[0] && !shp0 |-> eg_queue_out[1:0] == $past(top))
		else $error("strict order broken");
endmodule // smq_switch_qos_monitor
bind smq_switch_qos smq_switch_qos_monitor u_smq_switch_qos_monitor (.clk_in, .rst_in,
	.avs_address_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .in_valid_in,
	.in_port_in, .in_hit_in, .in_mcast_in, .in_bcast_in, .in_vid_miss_in, .in_mld_in,
	.in_err_in, .fwd_valid_out, .fwd_mask_out, .fwd_drop_out, .eg_ready_in, .eg_pending_in,
	.eg_grant_out, .eg_queue_out);
`default_nettype wire

//--- verif/test_smq_switch_qos.sv
// self-checking bench for the mirror/qos block
`default_nettype none
module test_smq_switch_qos;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;	// 10 MHz
	logic        rst_in = 1'b1;
	logic [7:0]  adr = 8'h00;	// register bus
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic        iv = 1'b0;	// descriptor
	logic [1:0]  ip = 2'h0;
	logic [1:0]  ipr = 2'h0;
	logic [10:0] ilen = 11'h040;
	logic [5:0]  fl = 6'h00;	// err, mld, vid miss, mcast, bcast, hit
	logic [2:0]  ihm = 3'h0;
	logic        fv, fd;
	logic [2:0]  fm;
	logic [5:0]  spd = 6'h15;	// all ports 100M
	logic [11:0] pend = 12'h000;
	logic [2:0]  rdy, done, gnt;
	logic [32:0] dlen;
	logic [5:0]  q;
	logic [12:0] ctrl;	// expected control word
	logic [11:0] unk;	// expected unknown groups
	int          miscompares = 0;
	int          checked = 0;
	always #50 clk_in = ~clk_in;
	smq_switch_qos #(.BURST_BITS(4096)) u_smq_switch_qos (.clk_in(clk_in), .rst_in(rst_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.in_valid_in(iv), .in_port_in(ip), .in_prio_in(ipr), .in_len_in(ilen),
		.in_mcast_in(fl[2]), .in_bcast_in(fl[1]), .in_hit_in(fl[0]), .in_hit_mask_in(ihm),
		.in_vid_miss_in(fl[3]), .in_mld_in(fl[4]), .in_err_in(fl[5]), .fwd_valid_out(fv),
		.fwd_mask_out(fm), .fwd_drop_out(fd), .link_speed_in(spd), .eg_pending_in(pend),
		.eg_ready_in(rdy), .eg_done_in(done), .eg_done_len_in(dlen), .eg_grant_out(gnt),
		.eg_queue_out(q));
	smq_mac_model u_smq_mac_model (.clk_in(clk_in), .rst_in(rst_in), .grant_in(gnt),
		.ready_out(rdy), .done_out(done), .done_len_out(dlen));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one bus cycle; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		// waitrequest seen at each rising edge, before that edge's updates
		do begin
			@(posedge clk_in);
			n++;
		end while (wreq !== 1'b0 && n < 40);
		if (n >= 40) begin
			miscompares++;
			close_out();
		end
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_in);	// idle edge keeps drivers single per step
	endtask
	// one descriptor; decision sampled mid-cycle after it
	task automatic fwd(input logic [1:0] p, input logic [2:0] hm, input logic [5:0] f,
		input logic [10:0] len, output logic [2:0] m, output logic dr);
		ip <= p;
		ihm <= hm;
		fl <= f;
		ilen <= len;
		ipr <= 2'($urandom);
		iv <= 1'b1;
		@(posedge clk_in);
		iv <= 1'b0;
		@(negedge clk_in);
		chk(fv, 1'b1);
		m = fm;	// drop stands only this cycle; the mask is recomputed every cycle
		dr = fd;
		@(posedge clk_in);
	endtask
	// wait for a port 0 grant and report its queue
	task automatic wgnt(output logic [1:0] qq);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (gnt[0] !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			miscompares++;
			close_out();
		end
		qq = q[1:0];
		@(posedge clk_in);
	endtask
	function automatic logic [2:0] grp(input logic [3:0] g);
		return g[3] ? g[2:0] : 3'h7;	// disabled group floods
	endfunction
	// expected destination set under the current configuration
	function automatic logic [2:0] expm(input logic [1:0] p, input logic [5:0] f,
		input logic [2:0] hm);
		logic [2:0] ib, sb, m;
		logic       rx;
		if (p == 2'h3) return 3'h0;
		ib = 3'h1 << p;
		sb = (ctrl[10:9] == 2'h3) ? 3'h0 : 3'h1 << ctrl[10:9];
		rx = ctrl[3 + p];
		if (f[5]) return (ctrl[12] && rx) ? sb & ~ib : 3'h0;
		if (f[4]) return ctrl[2:0] & (~ctrl[2:0] + 3'h1) & ~ib;
		// an unknown vid outranks a lookup hit
		m = f[3] ? grp(unk[11:8]) : f[0] ? hm : f[2] ? grp(unk[7:4]) : grp(unk[3:0]);
		m = m & ~ib;
		if (ctrl[11] ? rx && (m & ctrl[8:6]) != 0 : rx || (m & ctrl[8:6]) != 0) m = m | sb;
		return m & ~ib;
	endfunction
	function automatic logic [1:0] top(input logic [3:0] d);
		return d[3] ? 2'h3 : d[2] ? 2'h2 : {1'b0, d[1]};
	endfunction
	initial begin
		logic [31:0] r;
		logic [5:0]  f;
		logic [1:0]  qq;
		logic [2:0]  sm;	// decision mask seen
		logic        sd;	// drop flag seen
		int          cnt [4];
		int          n, d;
		static logic [7:0]  radr [7] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h30, 8'h40, 8'hfc};
		static logic [31:0] rrst [7] = '{32'h600, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
		// speed, rate, frame type, drops expected
		static logic [12:0] rt [5] = '{13'h809, 13'hb28, 13'h058, 13'h051, 13'h80c};
		void'($urandom(62));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		bus(1'b1, 8'hfc, 32'hffff_ffff, r);	// unmapped write ignored
		foreach (radr[i]) begin
			bus(1'b0, radr[i], 32'h0, r);
			chk(r, rrst[i]);
		end
		// fixed corner first: discard unknowns, host port 1, then random setups
		for (int c = 0; c < 4; c++) begin
			ctrl = (c == 0) ? 13'h0606 : 13'($urandom);
			unk = (c == 0) ? 12'h888 : 12'($urandom);
			if (ctrl[2:0] == 3'h0) ctrl[0] = 1'b1;
			bus(1'b1, 8'h00, {19'h0, ctrl}, r);
			bus(1'b1, 8'h04, {20'h0, unk}, r);
			bus(1'b0, 8'h00, 32'h0, r);
			chk(r, {19'h0, ctrl});
			for (int i = 0; i < 30; i++) begin
				f = 6'($urandom);
				if (f[4]) f[5] = 1'b0;
				if (f[1]) f[2] = 1'b1;	// broadcast is a multicast
				spd <= 6'($urandom);
				fwd(2'($urandom), 3'($urandom), f, 11'($urandom_range(64, 1518)), sm, sd);
				chk(sm, expm(ip, f, ihm));
				chk(sd, expm(ip, f, ihm) == 3'h0);
			end
		end
		// ingress limits on port 0, back-to-back full frames
		foreach (rt[i]) begin
			spd <= {4'h5, rt[i][12:11]};
			bus(1'b1, 8'h10, {25'h0, rt[i][2:1], 5'h02}, r);
			bus(1'b1, 8'h20, {4{rt[i][10:3]}}, r);
			n = 0;
			repeat (6) begin
				fwd(2'h0, 3'h2, 6'h01, 11'd1500, sm, sd);
				n = n + sd;
			end
			chk(n != 0, rt[i][0]);
		end
		bus(1'b1, 8'h20, 32'h0, r);
		bus(1'b0, 8'h08, 32'h0, r);
		chk(r[15:0] != 16'h0, 1'b1);
		// strict priority with random work on the other ports
		for (int i = 0; i < 20; i++) begin
			d = $urandom_range(1, 15);
			pend <= {8'($urandom), 4'(d)};
			wgnt(qq);
			chk(qq, top(4'(d)));
		end
		// weighted round robin, all four queues busy
		bus(1'b1, 8'h10, 32'h6, r);
		pend <= 12'h00f;
		cnt = '{0, 0, 0, 0};
		repeat (30) begin
			wgnt(qq);
			cnt[qq]++;
		end
		chk(cnt[3] > cnt[1] && cnt[1] > cnt[0] && cnt[0] > 0, 1'b1);
		// egress limit on queue 3 lets queue 0 through
		bus(1'b1, 8'h10, 32'h2, r);
		bus(1'b1, 8'h30, 32'h0100_0000, r);
		pend <= 12'h009;
		cnt = '{0, 0, 0, 0};
		repeat (8) begin
			wgnt(qq);
			cnt[qq]++;
		end
		chk(cnt[0] > 0, 1'b1);
		close_out();
	end
endmodule // test_smq_switch_qos
`default_nettype wire
